// ### jid_pkg.sv
package jid_pkg;
  localparam int IR_W = 6;
  localparam int ID_W = 32;
  localparam int SYNC_W = 4;
  // Opcodes of the instruction register
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_IDCODE = 6'h02;
  localparam logic [5:0] OP_HIGHZ = 6'h03;
  localparam logic [5:0] OP_CAPTURE = 6'h2D;
  localparam logic [5:0] OP_CLAMP = 6'h3E;
  localparam logic [5:0] OP_BYPASS = 6'h3F;
  // Values taken at capture and after reset
  localparam logic BYP_CAPTURE = 1'h0;
  localparam logic ID_LSB = 1'h1;
  localparam logic [3:0] SYNC_RST = 4'h0;
  typedef enum logic [3:0] {
    JID_RESET = 4'h0,
    JID_IDLE = 4'h1,
    JID_SEL_DR = 4'h3,
    JID_CAP_DR = 4'h2,
    JID_SH_DR = 4'h6,
    JID_EX1_DR = 4'h7,
    JID_PAU_DR = 4'h5,
    JID_EX2_DR = 4'h4,
    JID_UPD_DR = 4'hC,
    JID_SEL_IR = 4'hD,
    JID_CAP_IR = 4'hF,
    JID_SH_IR = 4'hE,
    JID_EX1_IR = 4'hA,
    JID_PAU_IR = 4'hB,
    JID_EX2_IR = 4'h9,
    JID_UPD_IR = 4'h8
  } jid_tap_e;
  typedef enum logic [1:0] {
    JID_DR_BYP = 2'h0,
    JID_DR_BSR = 2'h1,
    JID_DR_ID = 2'h3
  } jid_dr_e;
endpackage : jid_pkg

// ### jid_sync_if.sv
`timescale 1ns/1ps
interface jid_sync_if #(parameter int W = 4);
  logic [W-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface : jid_sync_if

// ### jid_sync.sv
`timescale 1ns/1ps
module jid_sync #(
  parameter int W = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] raw_i,
  jid_sync_if.src sync
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_lvl;

  if (W < 1) begin : g_chk
    $error("jid_sync: width must be at least one");
  end

  // A change is taken only once the second and third stages agree
  always_comb begin
    next_lvl = (s2 & s3) | (sync.lvl & (s2 | s3));
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync.lvl <= '0;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
      s3 <= s2;
      sync.lvl <= next_lvl;
    end
  end
endmodule : jid_sync

// ### jid_top.sv
`timescale 1ns/1ps
module jid_top #(
  parameter int NPIN = 4,
  parameter logic [3:0] ID_VERSION = 4'h1,    // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234,  // Arbitrary value
  parameter logic [10:0] ID_MANUF = 11'h055   // Arbitrary value
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  input wire logic [NPIN-1:0] core_out_i,
  input wire logic [NPIN-1:0] core_oe_i,
  input wire logic [NPIN-1:0] pad_in_i,
  output logic [NPIN-1:0] pad_out_o,
  output logic [NPIN-1:0] pad_oe_n_o,
  output logic tdo_o,
  output logic tdo_oe_n_o
);
  localparam int BSR_W = 2 * NPIN;

  if (NPIN < 1) begin : g_chk
    $error("jid_top: at least one boundary pin is needed");
  end

  // ==========================================================
  // Pin synchronisers
  jid_sync_if #(.W(jid_pkg::SYNC_W)) pins ();
  jid_sync #(.W(jid_pkg::SYNC_W)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .raw_i({trst_n_i, tdi_i, tms_i, tck_i}),
    .sync(pins)
  );
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  assign {trst_n, tdi, tms, tck} = pins.lvl;

  // ==========================================================
  // TAP and scan registers
  jid_pkg::jid_tap_e state;
  jid_pkg::jid_tap_e next_state;
  logic tck_q;
  logic [5:0] ir;
  logic [5:0] next_ir;
  logic [5:0] ir_sh;
  logic [5:0] next_ir_sh;
  logic byp;
  logic next_byp;
  logic [jid_pkg::ID_W-1:0] id_sh;
  logic [jid_pkg::ID_W-1:0] next_id_sh;
  logic [BSR_W-1:0] bsr;
  logic [BSR_W-1:0] next_bsr;
  logic [BSR_W-1:0] latch;
  logic [BSR_W-1:0] next_latch;
  logic next_tdo;
  logic next_tdo_oe_n;
  logic rise;
  logic fall;
  jid_pkg::jid_dr_e dr_sel;
  logic drive_bsr;
  logic hiz;
  logic [BSR_W-1:0] bsr_cap;

  assign rise = tck & ~tck_q;
  assign fall = ~tck & tck_q;

  // All six bits decoded; reserved codes fall into bypass
  always_comb begin
    dr_sel = jid_pkg::JID_DR_BYP;
    drive_bsr = 1'b0;
    hiz = 1'b0;
    case (ir)
      jid_pkg::OP_EXTEST: begin
        dr_sel = jid_pkg::JID_DR_BSR;
        drive_bsr = 1'b1;
      end
      jid_pkg::OP_SAMPLE: dr_sel = jid_pkg::JID_DR_BSR;
      jid_pkg::OP_IDCODE: dr_sel = jid_pkg::JID_DR_ID;
      jid_pkg::OP_HIGHZ: hiz = 1'b1;
      jid_pkg::OP_CLAMP: drive_bsr = 1'b1;
      jid_pkg::OP_BYPASS: dr_sel = jid_pkg::JID_DR_BYP;
      default: dr_sel = jid_pkg::JID_DR_BYP;
    endcase
  end

  // Under EXTEST a pin's data cell watches the pad; otherwise it watches the core
  // while the core drives, so a sample shows what really sits on the wire
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (ir == jid_pkg::OP_EXTEST || !core_oe_i[i]) begin
        bsr_cap[i] = pad_in_i[i];
      end else begin
        bsr_cap[i] = core_out_i[i];
      end
      bsr_cap[NPIN+i] = core_oe_i[i];
    end
  end

  always_comb begin
    next_state = state;
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_byp = byp;
    next_id_sh = id_sh;
    next_bsr = bsr;
    next_latch = latch;
    next_tdo = tdo_o;
    next_tdo_oe_n = tdo_oe_n_o;
    if (!trst_n) begin
      next_state = jid_pkg::JID_RESET;
      next_ir = jid_pkg::OP_IDCODE;
      // Reset can strike mid-shift with TCK stopped; release TDO at once
      next_tdo_oe_n = 1'b1;
    end else if (rise) begin
      unique case (state)
        jid_pkg::JID_RESET: next_state = tms ? jid_pkg::JID_RESET : jid_pkg::JID_IDLE;
        jid_pkg::JID_IDLE: next_state = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_IDLE;
        jid_pkg::JID_SEL_DR: next_state = tms ? jid_pkg::JID_SEL_IR : jid_pkg::JID_CAP_DR;
        jid_pkg::JID_CAP_DR: next_state = tms ? jid_pkg::JID_EX1_DR : jid_pkg::JID_SH_DR;
        jid_pkg::JID_SH_DR: next_state = tms ? jid_pkg::JID_EX1_DR : jid_pkg::JID_SH_DR;
        jid_pkg::JID_EX1_DR: next_state = tms ? jid_pkg::JID_UPD_DR : jid_pkg::JID_PAU_DR;
        jid_pkg::JID_PAU_DR: next_state = tms ? jid_pkg::JID_EX2_DR : jid_pkg::JID_PAU_DR;
        jid_pkg::JID_EX2_DR: next_state = tms ? jid_pkg::JID_UPD_DR : jid_pkg::JID_SH_DR;
        jid_pkg::JID_UPD_DR: next_state = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_IDLE;
        jid_pkg::JID_SEL_IR: next_state = tms ? jid_pkg::JID_RESET : jid_pkg::JID_CAP_IR;
        jid_pkg::JID_CAP_IR: next_state = tms ? jid_pkg::JID_EX1_IR : jid_pkg::JID_SH_IR;
        jid_pkg::JID_SH_IR: next_state = tms ? jid_pkg::JID_EX1_IR : jid_pkg::JID_SH_IR;
        jid_pkg::JID_EX1_IR: next_state = tms ? jid_pkg::JID_UPD_IR : jid_pkg::JID_PAU_IR;
        jid_pkg::JID_PAU_IR: next_state = tms ? jid_pkg::JID_EX2_IR : jid_pkg::JID_PAU_IR;
        jid_pkg::JID_EX2_IR: next_state = tms ? jid_pkg::JID_UPD_IR : jid_pkg::JID_SH_IR;
        jid_pkg::JID_UPD_IR: next_state = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_IDLE;
      endcase
      // Five TMS-high rises reach reset from any state
      if (state == jid_pkg::JID_RESET) next_ir = jid_pkg::OP_IDCODE;
      if (state == jid_pkg::JID_CAP_IR) next_ir_sh = jid_pkg::OP_CAPTURE;
      if (state == jid_pkg::JID_SH_IR) next_ir_sh = {tdi, ir_sh[5:1]};
      if (state == jid_pkg::JID_UPD_IR) next_ir = ir_sh;
      // Only the selected register captures or shifts
      if (state == jid_pkg::JID_CAP_DR) begin
        unique case (dr_sel)
          jid_pkg::JID_DR_BYP: next_byp = jid_pkg::BYP_CAPTURE;
          jid_pkg::JID_DR_BSR: next_bsr = bsr_cap;
          jid_pkg::JID_DR_ID: next_id_sh = {ID_VERSION, ID_PART, ID_MANUF, jid_pkg::ID_LSB};
        endcase
      end
      if (state == jid_pkg::JID_SH_DR) begin
        unique case (dr_sel)
          jid_pkg::JID_DR_BYP: next_byp = tdi;
          jid_pkg::JID_DR_BSR: next_bsr = {tdi, bsr[BSR_W-1:1]};
          jid_pkg::JID_DR_ID: next_id_sh = {tdi, id_sh[jid_pkg::ID_W-1:1]};
        endcase
      end
      if (state == jid_pkg::JID_UPD_DR && dr_sel == jid_pkg::JID_DR_BSR) begin
        next_latch = bsr;
      end
    end else if (fall) begin
      next_tdo_oe_n = !(state == jid_pkg::JID_SH_DR || state == jid_pkg::JID_SH_IR);
      if (state == jid_pkg::JID_SH_IR) begin
        next_tdo = ir_sh[0];
      end else begin
        unique case (dr_sel)
          jid_pkg::JID_DR_BYP: next_tdo = byp;
          jid_pkg::JID_DR_BSR: next_tdo = bsr[0];
          jid_pkg::JID_DR_ID: next_tdo = id_sh[0];
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= jid_pkg::JID_RESET;
      tck_q <= 1'b0;
      ir <= jid_pkg::OP_IDCODE;
      ir_sh <= jid_pkg::OP_CAPTURE;
      byp <= jid_pkg::BYP_CAPTURE;
      id_sh <= '0;
      bsr <= '0;
      latch <= '0;
      tdo_o <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else begin
      state <= next_state;
      tck_q <= tck;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      byp <= next_byp;
      id_sh <= next_id_sh;
      bsr <= next_bsr;
      latch <= next_latch;
      tdo_o <= next_tdo;
      tdo_oe_n_o <= next_tdo_oe_n;
    end
  end

  // ==========================================================
  // Pin drive
  // Latches are not cleared by TAP reset; the tester must preload them
  // through SAMPLE before EXTEST or CLAMP, else stale values reach the pins
  logic [NPIN-1:0] next_pad_out;
  logic [NPIN-1:0] next_pad_oe_n;

  always_comb begin
    if (hiz) begin
      next_pad_out = core_out_i;
      next_pad_oe_n = '1;
    end else if (drive_bsr) begin
      next_pad_out = latch[NPIN-1:0];
      next_pad_oe_n = ~latch[BSR_W-1:NPIN];
    end else begin
      next_pad_out = core_out_i;
      next_pad_oe_n = ~core_oe_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_n_o <= '1;
    end else begin
      pad_out_o <= next_pad_out;
      pad_oe_n_o <= next_pad_oe_n;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_ir_shift_in: assert property (trst_n && rise && state == jid_pkg::JID_SH_IR
    |=> ir_sh[5] == $past(tdi) && $stable(ir)) else $error("IR shift wrong");
  a_ir_update_latch: assert property (trst_n && rise && state == jid_pkg::JID_UPD_IR
    |=> ir == $past(ir_sh)) else $error("IR update wrong");
  a_ir_capture_val: assert property (trst_n && rise && state == jid_pkg::JID_CAP_IR
    |=> ir_sh == jid_pkg::OP_CAPTURE) else $error("IR capture wrong");
  a_byp_capture_zero: assert property (trst_n && rise && state == jid_pkg::JID_CAP_DR
    && dr_sel == jid_pkg::JID_DR_BYP |=> !byp) else $error("bypass capture wrong");
  a_reset_idcode: assert property (!trst_n |=> ir == jid_pkg::OP_IDCODE
    && state == jid_pkg::JID_RESET) else $error("reset not IDCODE");
  a_tdo_float: assert property (fall && state != jid_pkg::JID_SH_DR
    && state != jid_pkg::JID_SH_IR |=> tdo_oe_n_o) else $error("TDO driven");
  a_tdo_on_fall: assert property (!fall |=> $stable(tdo_o)) else $error("TDO moved");
  a_highz_pins: assert property (ir == jid_pkg::OP_HIGHZ |=> pad_oe_n_o == '1)
    else $error("HIGHZ pin driven");
  a_extest_drive: assert property (ir == jid_pkg::OP_EXTEST |=>
    pad_out_o == $past(latch[NPIN-1:0])) else $error("EXTEST drive wrong");
  a_sample_no_drive: assert property (ir == jid_pkg::OP_SAMPLE |=>
    pad_out_o == $past(core_out_i)) else $error("SAMPLE disturbed pins");

  c_extest: cover property (ir == jid_pkg::OP_EXTEST && rise && state == jid_pkg::JID_UPD_DR);
  c_idcode_shift: cover property (ir == jid_pkg::OP_IDCODE && rise
    && state == jid_pkg::JID_SH_DR);
  c_ir_update: cover property (rise && state == jid_pkg::JID_UPD_IR);
  c_clamp: cover property (ir == jid_pkg::OP_CLAMP);
endmodule : jid_top

// ### jid_tester.sv
`timescale 1ns/1ps
module jid_tester (
  input wire logic clock_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  // ==========================================
  // Idle levels
  // TCK rests low between frames; TMS and TDI sit at their pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // ==========================================
  // One TCK period of 200 ns: 4 clocks low, 4 clocks high
  // TDO is read at the end of the high phase, long after the fall that drove it
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (4) @(posedge clock_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    tdo = tdo_i;
    tck_o <= 1'b0;
  endtask : tick

  // Five TMS-high periods, then on to Run-Test/Idle
  task automatic tlr();
    logic b;
    repeat (5) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : tlr

  // ==========================================
  // Scan from Idle back to Idle, LSB first
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b1, b);
    if (ir) begin
      tick(1'b1, 1'b1, b);
    end
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tms_o <= 1'b1;
    tdi_o <= 1'b1;
    // Let an edge pass so a following tick never drives TMS in this same step
    @(posedge clock_i);
  endtask : scan
endmodule : jid_tester

// ### test_jid_top.sv
`timescale 1ns/1ps
module test_jid_top;
  localparam logic [3:0] T_VER = 4'h6;       // Arbitrary value
  localparam logic [15:0] T_PART = 16'hA5C3; // Arbitrary value
  localparam logic [10:0] T_MANUF = 11'h2B1; // Arbitrary value
  localparam logic [31:0] ID_EXP = {T_VER, T_PART, T_MANUF, 1'b1};
  localparam int LIMIT = 30000;
  logic clock_i;
  logic rst_i;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [3:0] core_out, core_oe, pad_in, pad_out, pad_oe_n;
  logic [63:0] d;
  int err_count, checks, cycles;

  jid_top #(.NPIN(4), .ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MANUF(T_MANUF)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .core_out_i(core_out), .core_oe_i(core_oe), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n));
  // A released TDO shows the inverse of its last value, so a late enable is caught
  jid_tester tester (.clock_i(clock_i), .tdo_i(tdo_oe_n ? ~tdo : tdo), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  always #12.5 clock_i = ~clock_i;

  // ==========================================
  // Checking and closing
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================
  // Helpers
  task automatic load_ir(input logic [5:0] op);
    tester.scan(1'b1, {58'h0, op}, 6, d);
    check(d[5:0], jid_pkg::OP_CAPTURE, "ir capture");
  endtask : load_ir

  task automatic pins(input logic [3:0] o, input logic [3:0] oe_n, input string what);
    repeat (8) @(posedge clock_i);
    check({pad_out, pad_oe_n}, {o, oe_n}, what);
    check(tdo_oe_n, 1'b1, "tdo idle");
  endtask : pins

  task automatic bypass_path();
    tester.scan(1'b0, 64'hD, 4, d);
    check(d[3:0], 4'hA, "bypass path");
  endtask : bypass_path

  // ==========================================
  // Scenarios
  task automatic t_id_reset();
    tester.scan(1'b0, 64'h0, 32, d);
    check(d[31:0], ID_EXP, "idcode");
    pins(core_out, ~core_oe, "pins normal");
  endtask : t_id_reset

  task automatic t_reserved();
    logic [5:0] ops [4] = '{6'h04, 6'h2C, 6'h2E, 6'h3D};
    foreach (ops[i]) begin
      core_out <= ops[i][3:0];
      core_oe <= ~ops[i][3:0];
      load_ir(ops[i]);
      bypass_path();
      pins(ops[i][3:0], ops[i][3:0], "reserved pins");
    end
    load_ir(jid_pkg::OP_BYPASS);
    bypass_path();
  endtask : t_reserved

  task automatic t_sample();
    core_out <= 4'h5;
    core_oe <= 4'h3;
    pad_in <= 4'hA;
    load_ir(jid_pkg::OP_SAMPLE);
    pins(4'h5, 4'hC, "sample pins");
    tester.scan(1'b0, 64'hF6, 8, d);
    check(d[7:0], 8'h39, "sample snapshot");
    pins(4'h5, 4'hC, "preload not driven");
  endtask : t_sample

  task automatic t_extest();
    load_ir(jid_pkg::OP_EXTEST);
    pins(4'h6, 4'h0, "extest latches");
    core_out <= 4'hA;
    tester.scan(1'b0, 64'h59, 8, d);
    check(d[3:0], 4'hA, "extest capture");
    pins(4'h9, 4'hA, "extest update");
  endtask : t_extest

  task automatic t_clamp_highz();
    load_ir(jid_pkg::OP_CLAMP);
    pins(4'h9, 4'hA, "clamp pins");
    bypass_path();
    load_ir(jid_pkg::OP_HIGHZ);
    // The new instruction reaches the pads one clock after the scan ends
    repeat (4) @(posedge clock_i);
    check(pad_oe_n, 4'hF, "highz");
    bypass_path();
    pins(4'hA, 4'hF, "highz hold");
  endtask : t_clamp_highz

  task automatic t_resets();
    logic b;
    tester.tlr();
    t_id_reset();
    load_ir(jid_pkg::OP_BYPASS);
    // Test reset acts without TCK; hold it well past the synchroniser delay
    trst_n <= 1'b0;
    repeat (8) @(posedge clock_i);
    trst_n <= 1'b1;
    repeat (8) @(posedge clock_i);
    // Only test reset may have restored IDCODE: step straight to Idle
    tester.tick(1'b0, 1'b1, b);
    t_id_reset();
  endtask : t_resets

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    trst_n = 1'b1;
    core_out = 4'h3;
    core_oe = 4'h9;
    pad_in = 4'h0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    tester.tlr();
    t_id_reset();
    load_ir(jid_pkg::OP_IDCODE);
    t_id_reset();
    t_reserved();
    t_sample();
    t_extest();
    t_clamp_highz();
    t_resets();
    wrap_up();
  end
endmodule : test_jid_top
